// ---- common/eipc_pkg.sv ----
// eipc_pkg: constants and carrier types for the second interrupt enable and
// priority bank and the two external interrupt inputs.
// assumes an 8-bit special-function bus driven by the core on the same clock.
package eipc_pkg;

  // special-function addresses
  localparam logic [7:0] EIPC_ADDR_ENABLE   = 8'h00E7; // enable bank two, all pages
  localparam logic [7:0] EIPC_ADDR_PRIORITY = 8'h00F7; // priority bank two, all pages
  localparam logic [7:0] EIPC_ADDR_EXTCFG   = 8'h00E4; // external input config
  localparam logic [7:0] EIPC_EXTCFG_PAGE   = 8'h0000; // config lives on page zero only

  // reset values
  localparam logic [3:0] EIPC_ENABLE_RESET   = 4'h0;
  localparam logic [3:0] EIPC_PRIORITY_RESET = 4'h0;
  localparam logic [7:0] EIPC_EXTCFG_RESET   = 8'h0001;

  // source bit positions inside the enable and priority banks
  localparam int EIPC_SRC_SPI1  = 3; // serial port one
  localparam int EIPC_SRC_OSCF  = 2; // clock oscillator fail
  localparam int EIPC_SRC_MATCH = 1; // port match
  localparam int EIPC_SRC_WARN  = 0; // supply early warning
  localparam int EIPC_NUM_SRC   = 4;
  localparam int EIPC_BANK_BITS = 4; // implemented low bits, 7:4 read zero

  // external config field layout, per input (index 0 = a, 1 = b)
  localparam int EIPC_CFG_FIELD = 4; // polarity + 3-bit select per input
  localparam int EIPC_CFG_POL   = 3; // polarity bit inside a field
  localparam int EIPC_SEL_BITS  = 3;

  // timer control register bits owned here (other bits read zero)
  localparam int EIPC_TIMER_CONTROL_REG_EDGE_A = 0; // edge mode, input a
  localparam int EIPC_TIMER_CONTROL_REG_PEND_A = 1; // pending, input a
  localparam int EIPC_TIMER_CONTROL_REG_EDGE_B = 2; // edge mode, input b
  localparam int EIPC_TIMER_CONTROL_REG_PEND_B = 3; // pending, input b

  // special-function bus request from the core
  typedef struct packed {
    logic [7:0] addr;  // special-function address
    logic [7:0] page;  // currently selected register page
    logic [7:0] wdata; // write data
    logic       wr;    // write strobe, one cycle
    logic       rd;    // read strobe, one cycle
  } eipc_sfr_req_t;

endpackage

// ---- verilog/eipc_ctrl.sv ----
// eipc_ctrl: enable/priority bank two plus external interrupt inputs a and b.
// assumes single-cycle sfr strobes from the core, peripheral requests on the
// same clock, and port 0 pins arriving asynchronously.
//
// Contract
// - enable/priority bits 7:4 read zero, ignore writes
// - enable bit 3 gates serial port one
// - enable bit 2 gates oscillator fail
// - enable bit 1 gates port match
// - enable bit 0 gates supply warning
// - priority bits 3:0 give each source high/low
// - enable at E7, priority at F7, all pages
// - each external input has its own polarity
// - edge-mode bit chooses edge or level sensing
// - inputs watch pins without touching crossbar
// - pending flags at timer control bits 1, 3
// - edge sets pending, vectoring clears it
// - level mode pending follows active input level
// - three-bit select picks port 0 pin
// - config at E4 page zero, b high a low
`timescale 1ns/1ps
`default_nettype none
module eipc_ctrl
  import eipc_pkg::*;
(
  input  wire logic                    clk,            // system clock
  input  wire logic                    rst_n,          // async reset, active low
  input  wire eipc_sfr_req_t           sfr_req,        // core register access
  output logic [7:0]                   sfr_rdata,      // read data, cycle after rd
  input  wire logic [EIPC_NUM_SRC-1:0] src_req,        // peripheral requests
  output logic [EIPC_NUM_SRC-1:0]      src_irq,        // masked requests to core
  output logic [EIPC_NUM_SRC-1:0]      src_high_prio,  // priority per source
  input  wire logic [7:0]              port0_pins,     // raw port 0 pin levels
  input  wire logic [1:0]              ext_vector_ack, // core vectors to ext routine
  output logic [1:0]                   ext_pending,    // pending flags a, b
  output logic [1:0]                   ext_high_prio   // unused slot kept low
);

  // timer control address is not part of this block's map; fixed here as a localparam, not overridable by the caller
  localparam logic [7:0] TIMER_CTRL_ADDR = 8'h0088;

  // address decode, used for every register
  function automatic logic sfr_hit(input eipc_sfr_req_t r, input logic [7:0] a,
                                   input logic paged);
    sfr_hit = (r.addr == a) && (!paged || (r.page == EIPC_EXTCFG_PAGE));
  endfunction

  // register state
  logic [EIPC_BANK_BITS-1:0] enable_q;    // irq_enable_bank_two, low nibble
  logic [EIPC_BANK_BITS-1:0] priority_q;  // irq_priority_bank_two, low nibble
  logic [7:0]                extcfg_q;    // ext_irq_config
  logic [1:0]                edge_mode_q; // ext_a_edge_mode, ext_b_edge_mode
  logic [1:0]                pending_q;   // ext_a_pending, ext_b_pending
  logic [7:0]                rdata_q;
  logic [EIPC_NUM_SRC-1:0]   irq_q;
  logic [7:0]                pin_meta_q;  // first sync stage, read by second only
  logic [7:0]                pin_sync_q;  // second sync stage
  logic [1:0]                act_prev_q;  // last active level after polarity

  // decoded strobes
  wire hit_en   = sfr_hit(sfr_req, EIPC_ADDR_ENABLE, 1'b0);
  wire hit_pr   = sfr_hit(sfr_req, EIPC_ADDR_PRIORITY, 1'b0);
  wire hit_cfg  = sfr_hit(sfr_req, EIPC_ADDR_EXTCFG, 1'b1);
  wire hit_timer_control_reg = sfr_hit(sfr_req, TIMER_CTRL_ADDR, 1'b0);
  wire wr_en    = sfr_req.wr && hit_en;
  wire wr_pr    = sfr_req.wr && hit_pr;
  wire wr_cfg   = sfr_req.wr && hit_cfg;
  wire wr_timer_control_reg  = sfr_req.wr && hit_timer_control_reg;

  // per-input derived signals
  logic [1:0] act_now;   // selected pin at its active level
  logic [1:0] edge_seen; // inactive-to-active transition this cycle
  logic [1:0] pend_d;
  logic [1:0] timer_control_reg_edge_w;
  logic [1:0] timer_control_reg_pend_w;
  assign timer_control_reg_edge_w = {sfr_req.wdata[EIPC_TIMER_CONTROL_REG_EDGE_B], sfr_req.wdata[EIPC_TIMER_CONTROL_REG_EDGE_A]};
  assign timer_control_reg_pend_w = {sfr_req.wdata[EIPC_TIMER_CONTROL_REG_PEND_B], sfr_req.wdata[EIPC_TIMER_CONTROL_REG_PEND_A]};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ext
      // pin picked from the synchronised pad copy, so crossbar users are untouched
      wire [EIPC_SEL_BITS-1:0] sel = extcfg_q[gi*EIPC_CFG_FIELD +: EIPC_SEL_BITS];
      wire pol = extcfg_q[gi*EIPC_CFG_FIELD + EIPC_CFG_POL];
      assign act_now[gi]   = pin_sync_q[sel] ~^ pol;
      assign edge_seen[gi] = act_now[gi] && !act_prev_q[gi];
      // level mode tracks pin; edge mode: set beats both clears
      assign pend_d[gi] = !edge_mode_q[gi] ? act_now[gi] :
                          edge_seen[gi] ? 1'b1 :
                          ext_vector_ack[gi] ? 1'b0 :
                          wr_timer_control_reg ? timer_control_reg_pend_w[gi] : pending_q[gi];
    end
  endgenerate

  // read mux; unused upper bits padded with zero
  wire [7:0] timer_control_reg_rd = {4'h0, pending_q[1], edge_mode_q[1], pending_q[0], edge_mode_q[0]};
  wire [7:0] rd_mux  = hit_en  ? {4'h0, enable_q}   :
                       hit_pr  ? {4'h0, priority_q} :
                       hit_cfg ? extcfg_q :
                       hit_timer_control_reg ? timer_control_reg_rd : 8'h0000;

  // pin synchroniser, two flops before anything looks at the pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= 8'h0000;
      pin_sync_q <= 8'h0000;
    end else begin
      pin_meta_q <= port0_pins;
      pin_sync_q <= pin_meta_q;
    end
  end

  // bank two registers; only the low nibble exists, so upper writes vanish
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q   <= EIPC_ENABLE_RESET;
      priority_q <= EIPC_PRIORITY_RESET;
    end else begin
      if (wr_en) enable_q <= sfr_req.wdata[EIPC_BANK_BITS-1:0];
      if (wr_pr) priority_q <= sfr_req.wdata[EIPC_BANK_BITS-1:0];
    end
  end

  // external configuration and edge-mode bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extcfg_q    <= EIPC_EXTCFG_RESET;
      edge_mode_q <= 2'b00;
    end else begin
      if (wr_cfg) extcfg_q <= sfr_req.wdata;
      if (wr_timer_control_reg) edge_mode_q <= timer_control_reg_edge_w;
    end
  end

  // pending flags and edge history; history seeded inactive, and the zeroed synchroniser
  // reads active at reset polarity, so both inputs see an edge in the first cycle after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_q  <= 2'b00;
      act_prev_q <= 2'b00;
    end else begin
      pending_q  <= pend_d;
      act_prev_q <= act_now;
    end
  end

  // masked requests and read data, registered so outputs come from flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q   <= '0;
      rdata_q <= 8'h0000;
    end else begin
      irq_q <= src_req & enable_q;
      if (sfr_req.rd) rdata_q <= rd_mux;
    end
  end

  assign sfr_rdata     = rdata_q;
  assign src_irq       = irq_q;
  assign src_high_prio = priority_q;
  assign ext_pending   = pending_q;
  assign ext_high_prio = 2'b00;

  // checks
  AST_UPPER_READ_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_req.rd && (hit_en || hit_pr) |=> sfr_rdata[7:4] == 4'h0)
    else $error("bank two upper bits read nonzero");
  AST_SPI_MASK: assert property (@(posedge clk) disable iff (!rst_n)
    !enable_q[EIPC_SRC_SPI1] && !wr_en |=> !src_irq[EIPC_SRC_SPI1])
    else $error("serial port one request passed while masked");
  AST_OSCF_MASK: assert property (@(posedge clk) disable iff (!rst_n)
    src_irq[EIPC_SRC_OSCF] == $past(src_req[EIPC_SRC_OSCF] && enable_q[EIPC_SRC_OSCF]))
    else $error("oscillator fail masking wrong");
  AST_MATCH_PASS: assert property (@(posedge clk) disable iff (!rst_n)
    enable_q[EIPC_SRC_MATCH] && src_req[EIPC_SRC_MATCH] |=> src_irq[EIPC_SRC_MATCH])
    else $error("enabled port match request lost");
  AST_WARN_MASK: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && !sfr_req.wdata[EIPC_SRC_WARN] |=> ##1 !src_irq[EIPC_SRC_WARN])
    else $error("supply warning passed after disable");
  AST_PRIO_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    wr_pr |=> src_high_prio == $past(sfr_req.wdata[3:0]))
    else $error("priority write not applied");
  AST_ANY_PAGE: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_req.wr && sfr_req.addr == EIPC_ADDR_ENABLE |=> enable_q == $past(sfr_req.wdata[3:0]))
    else $error("enable write ignored on some page");
  AST_CFG_PAGED: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_req.wr && sfr_req.addr == EIPC_ADDR_EXTCFG && sfr_req.page != EIPC_EXTCFG_PAGE
    |=> $stable(extcfg_q))
    else $error("config written from wrong page");
  AST_LEVEL_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
    !edge_mode_q[0] |=> ext_pending[0] == $past(act_now[0]))
    else $error("level pending does not follow input");
  AST_ACK_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
    edge_mode_q[0] && ext_vector_ack[0] && !edge_seen[0] |=> !ext_pending[0])
    else $error("vectoring did not clear edge pending");
  AST_EDGE_SETS: assert property (@(posedge clk) disable iff (!rst_n)
    edge_mode_q[1] && edge_seen[1] |=> ext_pending[1])
    else $error("edge did not set pending");
  AST_PIN_PATH: assert property (@(posedge clk) disable iff (!rst_n)
    edge_mode_q[0] && $rose(act_now[0]) |=> ext_pending[0])
    else $error("active transition not latched");
  AST_TIMER_CONTROL_REG_READ: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_req.rd && hit_timer_control_reg |=> sfr_rdata[EIPC_TIMER_CONTROL_REG_PEND_B] == $past(pending_q[1]))
    else $error("pending flag not at its timer control bit");
  COV_EDGE_ACK: cover property (@(posedge clk) disable iff (!rst_n)
    edge_mode_q[0] && ext_pending[0] ##[1:20] ext_vector_ack[0]);
  COV_LEVEL: cover property (@(posedge clk) disable iff (!rst_n)
    !edge_mode_q[1] && $rose(ext_pending[1]));
  COV_MASKED: cover property (@(posedge clk) disable iff (!rst_n)
    src_req[EIPC_SRC_SPI1] && !enable_q[EIPC_SRC_SPI1]);

endmodule
`default_nettype wire

// ---- verif/eipc_src_model.sv ----
// eipc_src_model: external interrupt source sitting on port 0 pins.
// assumes the bench sets idle pin levels and pulses the core's ack.
`timescale 1ns/1ps
`default_nettype none
module eipc_src_model (
  input  wire logic       clk,   // system clock
  input  wire logic       rst_n, // async reset, active low
  input  wire logic [1:0] fire,  // start a request, b and a
  input  wire logic [1:0] ack,   // core vectors to the routine
  input  wire logic [1:0] pol,   // active level per input
  input  wire logic [5:0] sel,   // pin index b, then a
  input  wire logic [7:0] idle,  // pin levels while not requesting
  output logic      [7:0] pins   // driven port 0 levels
);
  logic [1:0] req_q; // request held per input

  // hold the line active until the core takes it, then drop at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= 2'h0;
    end else begin
      req_q <= (req_q | fire) & ~ack;
    end
  end

  // requesting inputs force their pin; crossbar levels stay elsewhere
  // selected pins are treated as skipped by the crossbar, so only we drive them
  always_comb begin
    pins = idle;
    if (req_q[0]) pins[sel[2:0]] = pol[0];
    if (req_q[1]) pins[sel[5:3]] = pol[1];
  end
endmodule
`default_nettype wire

// ---- verif/eipc_ctrl_tb.sv ----
// eipc_ctrl_tb: self-checking bench for the bank-two and external inputs.
// assumes eipc_pkg, eipc_ctrl and eipc_src_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module eipc_ctrl_tb;
  import eipc_pkg::*;
  typedef struct packed {logic [7:0] a, p, w, e;} eipc_row_t; // addr, page, wdata, readback
  logic          clk;
  logic          rst_n;
  eipc_sfr_req_t sfr_req;
  logic [7:0]    sfr_rdata, port0_pins, idle;
  logic [3:0]    src_req, src_irq, src_high_prio;
  logic [1:0]    ack, ext_pending, ext_high_prio, fire, pol;
  logic [5:0]    sel;
  int            n_fail, comparisons;
  // upper bits dropped, all pages for bank two, config reads zero off page zero
  eipc_row_t     rows [6] = '{32'hE700_FF0F, 32'hE705_A606, 32'hF703_A505,
                              32'hF700_0000, 32'hE401_5500, 32'h1200_FF00};

  eipc_ctrl u_dut (.clk(clk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .src_req(src_req), .src_irq(src_irq), .src_high_prio(src_high_prio),
    .port0_pins(port0_pins), .ext_vector_ack(ack), .ext_pending(ext_pending),
    .ext_high_prio(ext_high_prio));
  eipc_src_model u_src (.clk(clk), .rst_n(rst_n), .fire(fire), .ack(ack), .pol(pol),
    .sel(sel), .idle(idle), .pins(port0_pins));

  // free-running 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // inputs move 1 ns after the edge so sampling never races
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one-cycle strobe; read data lands at the edge that takes it and holds
  // an idle cycle follows so back-to-back calls never retouch the strobe at once
  task automatic sfr(input logic [7:0] a, p, w, input logic wr);
    sfr_req = '{addr: a, page: p, wdata: w, wr: wr, rd: !wr};
    step(1);
    sfr_req = '0;
    step(1);
  endtask

  task automatic rd_chk(input logic [7:0] a, p, e);
    sfr(a, p, 8'h00, 1'b0);
    check(sfr_rdata, e);
  endtask

  task automatic pulse_ack(input logic [1:0] v);
    ack = v;
    step(1);
    ack = 2'h0;
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, far beyond the whole sequence
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  initial begin
    {rst_n, n_fail, comparisons} = '0;
    sfr_req = '0;
    src_req = 4'h0;
    idle = 8'hFF;
    {ack, fire, pol, sel} = 12'h000;
    step(12);
    check({src_irq, src_high_prio}, 8'h00);
    check({ext_pending, ext_high_prio}, {4'h0, 4'h0});
    rst_n = 1'b1;
    step(3);
    rd_chk(8'hE7, 8'h00, 8'h00);
    rd_chk(8'hF7, 8'h00, 8'h00);
    rd_chk(8'hE4, 8'h00, 8'h01);
    rd_chk(8'h88, 8'h00, 8'h00);
    foreach (rows[i]) begin
      sfr(rows[i].a, rows[i].p, rows[i].w, 1'b1);
      rd_chk(rows[i].a, rows[i].p, rows[i].e);
    end
    // one enabled source at a time, priority as the complement
    src_req = 4'hF;
    for (int i = 0; i < 4; i++) begin
      sfr(8'hE7, 8'h00, 8'h01 << i, 1'b1);
      sfr(8'hF7, 8'h00, 8'h0F ^ (8'h01 << i), 1'b1);
      step(1);
      check({4'h0, src_irq}, 8'h01 << i);
      check({4'h0, src_high_prio}, 8'h0F ^ (8'h01 << i));
    end
    src_req = 4'h5;
    step(2);
    check({4'h0, src_irq}, 8'h00);
    // b active high on pin 5, a active low on pin 2, both edge mode
    idle = 8'hDF;
    sfr(8'hE4, 8'h00, 8'hD2, 1'b1);
    sfr(8'h88, 8'h00, 8'h05, 1'b1);
    {pol, sel} = {2'b10, 3'd5, 3'd2};
    step(4);
    pulse_ack(2'h3);
    step(1);
    check({6'h0, ext_pending}, 8'h00);
    fire = 2'h3;
    step(1);
    fire = 2'h0;
    step(4);
    rd_chk(8'h88, 8'h00, 8'h0F);
    pulse_ack(2'h1);
    step(1);
    check({6'h0, ext_pending}, 8'h02);
    pulse_ack(2'h2);
    // level mode: flag tracks the line, software clear ignored
    sfr(8'h88, 8'h00, 8'h00, 1'b1);
    fire = 2'h1;
    step(1);
    fire = 2'h0;
    step(4);
    check({6'h0, ext_pending}, 8'h01);
    sfr(8'h88, 8'h00, 8'h00, 1'b1);
    step(4);
    check({6'h0, ext_pending}, 8'h01);
    pulse_ack(2'h1);
    step(4);
    check({6'h0, ext_pending}, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
